//--- hdl/sdd_ctrl.v
// Self-diagnosis and load-state display controller with AXI4-Lite port.
// Assumes sensor readings, buttons and load commands synchronous to clock.
`timescale 1ns/1ps
`include "sdd_defs.vh"

module sdd_ctrl #(
  parameter HALF_CYC = `SDD_HALF_CYC
) (
  input  wire        CLOCK_IN,
  input  wire        RESET_N_IN,
  // AXI4-Lite slave
  input  wire [3:0]  S_AXI_AWADDR_IN,
  input  wire        S_AXI_AWVALID_IN,
  output wire        S_AXI_AWREADY_OUT,
  input  wire [31:0] S_AXI_WDATA_IN,
  input  wire [3:0]  S_AXI_WSTRB_IN,
  input  wire        S_AXI_WVALID_IN,
  output wire        S_AXI_WREADY_OUT,
  output wire [1:0]  S_AXI_BRESP_OUT,
  output wire        S_AXI_BVALID_OUT,
  input  wire        S_AXI_BREADY_IN,
  input  wire [3:0]  S_AXI_ARADDR_IN,
  input  wire        S_AXI_ARVALID_IN,
  output wire        S_AXI_ARREADY_OUT,
  output wire [31:0] S_AXI_RDATA_OUT,
  output wire [1:0]  S_AXI_RRESP_OUT,
  output wire        S_AXI_RVALID_OUT,
  input  wire        S_AXI_RREADY_IN,
  // Sensor readings, signed degrees C
  input  wire [7:0]  TEMP_ICE_IN,
  input  wire [7:0]  TEMP_REF_AIR_IN,
  input  wire [7:0]  TEMP_REF_DEF_IN,
  input  wire [7:0]  TEMP_AMBIENT_IN,
  input  wire [7:0]  TEMP_FRZ_AIR_IN,
  input  wire [7:0]  TEMP_FRZ_DEF_IN,
  // Ice-maker mechanism
  input  wire        ICE_EJECT_IN,
  input  wire        ICE_NORMAL_IN,
  // Panel buttons
  input  wire        BTN_FRZ_BOOST_IN,
  input  wire        BTN_REF_BOOST_IN,
  input  wire        BTN_REF_SET_IN,
  // Normal setting display from the main controller
  input  wire [4:0]  NORM_FRZ_LED_IN,
  input  wire [4:0]  NORM_REF_LED_IN,
  input  wire        NORM_FRZ_BOOST_IN,
  input  wire        NORM_REF_BOOST_IN,
  // Commanded load outputs
  input  wire        LOAD_COMP_IN,
  input  wire        LOAD_FRZ_FAN_IN,
  input  wire        LOAD_FRZ_HEAT_IN,
  input  wire        LOAD_REF_FAN_IN,
  input  wire        LOAD_REF_HEAT_IN,
  input  wire        START_MODE_IN,
  // Panel outputs
  output wire [4:0]  FRZ_LED_OUT,
  output wire [4:0]  REF_LED_OUT,
  output wire        FRZ_BOOST_LED_OUT,
  output wire        REF_BOOST_LED_OUT,
  output wire        ALARM_OUT,
  output wire        CONFIRM_CHIME_OUT
);

  // Mode states
  localparam [3:0] S_POR   = 4'h0;
  localparam [3:0] S_PERR  = 4'h1;
  localparam [3:0] S_NORM  = 4'h2;
  localparam [3:0] S_HOLD  = 4'h3;
  localparam [3:0] S_BLINK = 4'h4;
  localparam [3:0] S_RDIAG = 4'h5;
  localparam [3:0] S_RERR  = 4'h6;
  localparam [3:0] S_LOAD  = 4'h7;

  localparam [6:0] T_POR   = `SDD_TICKS(`SDD_POR_S);
  localparam [6:0] T_ARM   = `SDD_TICKS(`SDD_ARM_S);
  localparam [6:0] T_DIAG  = `SDD_TICKS(`SDD_DIAG_S);
  localparam [6:0] T_BLINK = `SDD_TICKS(`SDD_BLINK_S);
  localparam [6:0] T_SHOW  = `SDD_TICKS(`SDD_SHOW_S);
  localparam [6:0] T_STEPS = 7'h08;
  localparam [31:0] HALF_LAST = HALF_CYC - 1;

  // Out-of-range test on one signed sensor reading
  function sens_bad;
    input [7:0] t;
    begin
      sens_bad = ($signed(t) > $signed(8'sd50)) ||
                 ($signed(t) < $signed(-8'sd50));
    end
  endfunction

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [31:0] cyc_reg;
  reg  [6:0]  tcnt_reg;
  reg  [7:0]  fault_reg;
  reg  [1:0]  eject_cnt_reg;
  reg         ref_set_prev_reg;
  reg         ice_model_reg;
  reg         cancel_reg;
  reg         chime_next;
  reg         alarm_next;
  reg  [4:0]  frz_next;
  reg  [4:0]  ref_next;
  reg         fbst_next;
  reg         rbst_next;
  reg  [4:0]  frz_reg;
  reg  [4:0]  ref_reg;
  reg         fbst_reg;
  reg         rbst_reg;
  reg         alarm_reg;
  reg         chime_reg;
  wire        tick;
  wire        both_held;
  wire        set_press;
  wire [7:0]  fault_now;
  wire        blink_on;

  // Bus signals
  reg         awready_reg;
  reg         wready_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg  [3:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         arready_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;

  assign tick      = (cyc_reg == HALF_LAST);
  assign both_held = BTN_FRZ_BOOST_IN & BTN_REF_BOOST_IN;
  assign set_press = BTN_REF_SET_IN & ~ref_set_prev_reg;
  assign blink_on  = ~tcnt_reg[0];

  // Live fault vector; bit order follows the LED map below
  // range limits
  assign fault_now[0] = ice_model_reg & sens_bad(TEMP_ICE_IN);
  assign fault_now[1] = sens_bad(TEMP_REF_AIR_IN);
  assign fault_now[2] = sens_bad(TEMP_REF_DEF_IN);
  assign fault_now[3] = ice_model_reg &
                        (eject_cnt_reg == `SDD_EJECT_MAX);
  assign fault_now[4] = sens_bad(TEMP_AMBIENT_IN);
  assign fault_now[5] = sens_bad(TEMP_FRZ_AIR_IN);
  assign fault_now[6] = sens_bad(TEMP_FRZ_DEF_IN);
  assign fault_now[7] = 1'b0;

  // Ice-maker eject attempts, cleared once it runs normally again
  // count to three
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      eject_cnt_reg <= 2'h0;
    end else if (ICE_NORMAL_IN) begin
      eject_cnt_reg <= 2'h0;
    end else if (ICE_EJECT_IN && eject_cnt_reg != `SDD_EJECT_MAX) begin
      eject_cnt_reg <= eject_cnt_reg + 2'h1;
    end
  end

  // Half-second time base, restarted on every state change
  // restart on release
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cyc_reg  <= 32'h0;
      tcnt_reg <= 7'h0;
    end else if (state_next != state_reg) begin
      cyc_reg  <= 32'h0;
      tcnt_reg <= 7'h0;
    end else if (tick) begin
      cyc_reg  <= 32'h0;
      tcnt_reg <= (tcnt_reg == 7'h7f) ? tcnt_reg : tcnt_reg + 7'h1;
    end else begin
      cyc_reg  <= cyc_reg + 32'h1;
    end
  end

  // Mode sequencing
  always @* begin
    state_next = state_reg;
    chime_next = 1'b0;
    case (state_reg)
      S_POR: begin
        if (tcnt_reg == T_POR) begin
          state_next = (|fault_now) ? S_PERR : S_NORM;
        end
      end
      S_PERR: begin
        if (!(|fault_now) || cancel_reg) begin
          state_next = S_NORM;
        end
      end
      S_NORM: begin
        if (both_held) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!both_held) begin
          state_next = (tcnt_reg >= T_ARM) ? S_BLINK : S_NORM;
        end else if (tcnt_reg == T_DIAG) begin
          state_next = S_RDIAG;
          chime_next = 1'b1;
        end
      end
      S_BLINK: begin
        if (set_press) begin
          state_next = S_LOAD;
          chime_next = 1'b1;
        end else if (tcnt_reg == T_BLINK) begin
          state_next = S_NORM;
        end
      end
      S_RDIAG: begin
        if (tcnt_reg == T_STEPS) begin
          if (|fault_now) begin
            state_next = S_RERR;
          end else begin
            state_next = S_NORM;
            chime_next = 1'b1;
          end
        end
      end
      S_RERR: begin
        if (tcnt_reg == T_SHOW) begin
          state_next = S_NORM;
          chime_next = 1'b1;
        end
      end
      S_LOAD: begin
        if (tcnt_reg == T_SHOW) begin
          state_next = S_NORM;
        end
      end
      default: begin
        state_next = S_NORM;
      end
    endcase
  end

  // Fault snapshot at the end of each check and while the power-on error shows
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg        <= S_POR;
      fault_reg        <= 8'h00;
      ref_set_prev_reg <= 1'b0;
    end else begin
      state_reg        <= state_next;
      ref_set_prev_reg <= BTN_REF_SET_IN;
      if (state_reg == S_POR || state_reg == S_PERR ||
          state_reg == S_RDIAG) begin
        fault_reg <= fault_now;
      end
    end
  end

  // Panel contents per mode
  always @* begin
    frz_next   = NORM_FRZ_LED_IN;
    ref_next   = NORM_REF_LED_IN;
    fbst_next  = NORM_FRZ_BOOST_IN;
    rbst_next  = NORM_REF_BOOST_IN;
    alarm_next = 1'b0;
    case (state_reg)
      S_POR: begin
        frz_next  = 5'h1f;
        ref_next  = 5'h1f;
        fbst_next = 1'b1;
        rbst_next = 1'b1;
      end
      S_PERR, S_RERR: begin
        frz_next   = blink_on ? {2'h0, fault_reg[6:4]} : 5'h00;
        ref_next   = blink_on ? {1'b0, fault_reg[3:0]} : 5'h00;
        fbst_next  = 1'b0;
        rbst_next  = 1'b0;
        alarm_next = 1'b1;
      end
      // all setting LEDs on while held past arm time
      S_HOLD: begin
        if (tcnt_reg >= T_ARM) begin
          frz_next = 5'h1f;
          ref_next = 5'h1f;
        end
      end
      S_BLINK: begin
        frz_next = blink_on ? 5'h1f : 5'h00;
        ref_next = blink_on ? 5'h1f : 5'h00;
      end
      // all setting LEDs on during checks
      S_RDIAG: begin
        frz_next = 5'h1f;
        ref_next = 5'h1f;
      end
      S_LOAD: begin
        frz_next  = {($signed(TEMP_AMBIENT_IN) < $signed(8'sd17)), 1'b0,
                     LOAD_FRZ_HEAT_IN, LOAD_FRZ_FAN_IN, LOAD_COMP_IN};
        ref_next  = {3'h0, LOAD_REF_HEAT_IN, LOAD_REF_FAN_IN};
        fbst_next = START_MODE_IN;
        rbst_next = ($signed(TEMP_AMBIENT_IN) > $signed(8'sd35));
      end
      default: begin
        alarm_next = 1'b0;
      end
    endcase
  end

  // Every panel output straight from a flop
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      frz_reg   <= 5'h1f;
      ref_reg   <= 5'h1f;
      fbst_reg  <= 1'b1;
      rbst_reg  <= 1'b1;
      alarm_reg <= 1'b0;
      chime_reg <= 1'b0;
    end else begin
      frz_reg   <= frz_next;
      ref_reg   <= ref_next;
      fbst_reg  <= fbst_next;
      rbst_reg  <= rbst_next;
      alarm_reg <= alarm_next;
      chime_reg <= chime_next;
    end
  end

  assign FRZ_LED_OUT       = frz_reg;
  assign REF_LED_OUT       = ref_reg;
  assign FRZ_BOOST_LED_OUT = fbst_reg;
  assign REF_BOOST_LED_OUT = rbst_reg;
  assign ALARM_OUT         = alarm_reg;
  assign CONFIRM_CHIME_OUT = chime_reg;

  // Write channel: address and data taken in either order, one at a time
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      awready_reg   <= 1'b1;
      wready_reg    <= 1'b1;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `SDD_RESP_OKAY;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      ice_model_reg <= `SDD_CTRL_RST;
      cancel_reg    <= 1'b0;
    end else begin
      cancel_reg <= 1'b0;
      if (S_AXI_AWVALID_IN && awready_reg) begin
        awaddr_reg  <= S_AXI_AWADDR_IN;
        awready_reg <= 1'b0;
      end
      if (S_AXI_WVALID_IN && wready_reg) begin
        wdata_reg  <= S_AXI_WDATA_IN;
        wstrb_reg  <= S_AXI_WSTRB_IN;
        wready_reg <= 1'b0;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        bvalid_reg <= 1'b1;
        if (awaddr_reg == `SDD_OFS_CTRL) begin
          bresp_reg <= `SDD_RESP_OKAY;
          if (wstrb_reg[0]) begin
            ice_model_reg <= wdata_reg[`SDD_CTRL_ICE_BIT];
            cancel_reg    <= wdata_reg[`SDD_CTRL_CAN_BIT];
          end
        end else if (awaddr_reg == `SDD_OFS_STATUS ||
                     awaddr_reg == `SDD_OFS_FAULT) begin
          bresp_reg <= `SDD_RESP_OKAY;
        end else begin
          bresp_reg <= `SDD_RESP_SLVERR;
        end
      end
      if (bvalid_reg && S_AXI_BREADY_IN) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read channel: answer one edge after the address is taken
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `SDD_RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `SDD_RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        `SDD_OFS_CTRL:   rdata_reg <= {31'h0, ice_model_reg};
        `SDD_OFS_STATUS: rdata_reg <= {26'h0, ice_model_reg,
                                       alarm_reg, state_reg};
        `SDD_OFS_FAULT:  rdata_reg <= {24'h0, fault_now};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= `SDD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY_IN) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign S_AXI_AWREADY_OUT = awready_reg;
  assign S_AXI_WREADY_OUT  = wready_reg;
  assign S_AXI_BVALID_OUT  = bvalid_reg;
  assign S_AXI_BRESP_OUT   = bresp_reg;
  assign S_AXI_ARREADY_OUT = arready_reg;
  assign S_AXI_RVALID_OUT  = rvalid_reg;
  assign S_AXI_RDATA_OUT   = rdata_reg;
  assign S_AXI_RRESP_OUT   = rresp_reg;

endmodule

//--- hdl/sdd_defs.vh
// Constants for the self-diagnosis and load display controller.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register port.
`ifndef SDD_DEFS_VH
`define SDD_DEFS_VH

// Register byte offsets
`define SDD_OFS_CTRL      4'h0
`define SDD_OFS_STATUS    4'h4
`define SDD_OFS_FAULT     4'h8

// Control register fields
`define SDD_CTRL_ICE_BIT  0
`define SDD_CTRL_CAN_BIT  1
`define SDD_CTRL_RST      1'b1

// Status register fields
`define SDD_ST_STATE_LSB  0
`define SDD_ST_ALARM_BIT  4
`define SDD_ST_MODEL_BIT  5

// Bus answers
`define SDD_RESP_OKAY     2'b00
`define SDD_RESP_SLVERR   2'b10

// Clock and time base
`define SDD_CLK_MHZ       40
`define SDD_HALF_SEC_MS   500
`define SDD_HALF_CYC      (`SDD_HALF_SEC_MS * `SDD_CLK_MHZ * 1000)

// Times in seconds, turned into half-second ticks
`define SDD_POR_S         1
`define SDD_ARM_S         3
`define SDD_DIAG_S        5
`define SDD_BLINK_S       2
`define SDD_SHOW_S        30
`define SDD_TICKS(s)      ((s) * 2)

// Sensor fault limits and ambient mode bands, degrees C
`define SDD_FAULT_HI      50
`define SDD_FAULT_LO      (-50)
`define SDD_AMB_HOT       35
`define SDD_AMB_COOL      17
`define SDD_EJECT_MAX     3

`endif

//--- verification/appliance_self_diagnosis_display_tb_top.sv
// Bench for the self-diagnosis and load display controller.
// Assumes HALF_CYC of 8 clocks; read results are checked from a queue.
`timescale 1ns/1ps
module appliance_self_diagnosis_display_tb_top;
  localparam int HC = 8;
  int          amb[4] = '{10, 17, 35, 36};
  logic        clk, rst_n, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv;
  logic        ejg, nset, ejo, nrm, bf, brb, bset, fbl, rbl, alarm, chime;
  logic [3:0]  awa, ara, wst;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp, ejn;
  logic [47:0] tset, tbus;
  logic [11:0] nd;
  logic [5:0]  ld;
  logic [4:0]  bl;
  logic [4:0]  fled, rled;
  logic [33:0] expq[$];
  int          n_mismatch, checked, n_chime, seed, i, j, k;

  sdd_ctrl #(.HALF_CYC(HC)) i_sdd_ctrl (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(wst), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre),
    .TEMP_ICE_IN(tbus[7:0]), .TEMP_REF_AIR_IN(tbus[15:8]),
    .TEMP_REF_DEF_IN(tbus[23:16]), .TEMP_AMBIENT_IN(tbus[31:24]),
    .TEMP_FRZ_AIR_IN(tbus[39:32]), .TEMP_FRZ_DEF_IN(tbus[47:40]),
    .ICE_EJECT_IN(ejo), .ICE_NORMAL_IN(nrm), .BTN_FRZ_BOOST_IN(bf),
    .BTN_REF_BOOST_IN(brb), .BTN_REF_SET_IN(bset),
    .NORM_FRZ_LED_IN(nd[9:5]), .NORM_REF_LED_IN(nd[4:0]),
    .NORM_FRZ_BOOST_IN(nd[10]), .NORM_REF_BOOST_IN(nd[11]),
    .LOAD_COMP_IN(ld[0]), .LOAD_FRZ_FAN_IN(ld[1]), .LOAD_FRZ_HEAT_IN(ld[2]),
    .LOAD_REF_FAN_IN(ld[3]), .LOAD_REF_HEAT_IN(ld[4]), .START_MODE_IN(ld[5]),
    .FRZ_LED_OUT(fled), .REF_LED_OUT(rled), .FRZ_BOOST_LED_OUT(fbl),
    .REF_BOOST_LED_OUT(rbl), .ALARM_OUT(alarm), .CONFIRM_CHIME_OUT(chime));

  sdd_panel_model i_sdd_panel_model (
    .clk_in(clk), .temp_set_in(tset), .eject_num_in(ejn), .eject_go_in(ejg),
    .normal_set_in(nset), .temp_out(tbus), .eject_out(ejo), .normal_out(nrm));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [33:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_of_test;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [33:0] st(input logic [3:0] s, input logic a);
    return {29'h1, a, s};
  endfunction

  // Write: ready raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'b00);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    expq.push_back({r, 32'h0});
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    pa = 1;
    pw = 1;
    pb = 1;
    for (n = 0; n < 40 && pb; n++) begin
      @(negedge clk);
      ta = pa && awr;
      tw = pw && wrd;
      tb = bv && bre;
      @(posedge clk);
      // Only changes are driven, so a following call never clashes
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (tb)
        bre <= 1'b0;
      else if (n > 1)
        bre <= 1'b1;
      pa = pa && !ta;
      pw = pw && !tw;
      pb = !tb;
    end
    if (pb) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  // Read: the expected word is queued before the request goes out
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic pa, pr, ta, tr;
    int n;
    expq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    pa = 1;
    pr = 1;
    for (n = 0; n < 40 && pr; n++) begin
      @(negedge clk);
      ta = pa && arr;
      tr = rv && rre;
      @(posedge clk);
      if (ta)
        arv <= 1'b0;
      if (tr)
        rre <= 1'b0;
      else if (n > 0)
        rre <= 1'b1;
      pa = pa && !ta;
      pr = !tr;
    end
    if (pr) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task ej(input logic [1:0] n);
    ejn <= n;
    ejg <= 1'b1;
    cyc(1);
    ejg <= 1'b0;
    cyc(10);
  endtask

  // Completed reads and writes against the oldest note; chimes counted
  always @(posedge clk) begin
    if (rv && rre) begin
      chk("read data", expq[0], {rresp, rdat});
      expq.pop_front();
    end
    if (bv && bre) begin
      chk("write resp", expq[0][33:32], bresp);
      expq.pop_front();
    end
    if (chime)
      n_chime++;
  end

  initial begin
    seed = 32'he080fdab;
    {awv, wv, bre, arv, rre, ejg, nset, bf, brb, bset} = 10'h000;
    {awa, ara, wd, ejn, ld} = 48'h0;
    wst = 4'hf;
    nd = 12'($random(seed));
    tset = {6{8'd20}};
    tset[31:24] = 8'd60;
    rst_n = 1'b0;
    cyc(10);
    chk("lamps", 10'h3ff, {fled, rled});
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    chk("lamps", 10'h3ff, {fled, rled});
    cyc(20);
    rd(4'h4, st(1, 1));
    rd(4'h8, 34'h10);
    chk("alarm", 1, alarm);
    bl = fled;
    cyc(HC);
    chk("fault blink", 1, bl[0] ^ fled[0]);
    tset[31:24] <= 8'd20;
    cyc(4);
    rd(4'h4, st(2, 0));
    chk("display", nd, {rbl, fbl, fled, rled});
    wr(4'hc, 32'h3, 2'b10);
    rd(4'h0, 34'h1);
    rd(4'hc, {2'b10, 32'h0});
    for (i = 0; i < 6; i++)
      for (j = 0; j < 4; j++) begin
        k = j < 2 ? 50 : 51;
        tset[i * 8 +: 8] <= 8'(j % 2 ? -k : k);
        cyc(3);
        rd(4'h8, j < 2 ? 34'h0 : 34'h1 << (i + (i > 2)));
        tset[i * 8 +: 8] <= 8'd20;
        cyc(3);
      end
    wr(4'h0, 32'h0);
    tset[7:0] <= 8'd60;
    ej(3);
    rd(4'h8, 34'h0);
    wr(4'h0, 32'h1);
    nset <= 1'b1;
    cyc(3);
    nset <= 1'b0;
    rd(4'h8, 34'h1);
    tset[7:0] <= 8'd20;
    ej(2);
    rd(4'h8, 34'h0);
    ej(1);
    rd(4'h8, 34'h8);
    // Ice maker recovers, else its fault spoils the clean diagnosis
    {bf, brb, nset} <= 3'b111;
    cyc(4 * HC);
    rd(4'h4, st(3, 0));
    {bf, brb, nset} <= 3'b000;
    cyc(3);
    rd(4'h4, st(2, 0));
    {bf, brb} <= 2'b11;
    cyc(7 * HC);
    chk("held", 10'h3ff, {fled, rled});
    {bf, brb} <= 2'b00;
    cyc(3);
    rd(4'h4, st(4, 0));
    bl = fled;
    cyc(HC);
    chk("blink", 5'h1f, bl ^ fled);
    bset <= 1'b1;
    cyc(2);
    bset <= 1'b0;
    cyc(3);
    rd(4'h4, st(7, 0));
    for (i = 0; i < 4; i++) begin
      ld <= 6'($random(seed));
      tset[31:24] <= 8'(amb[i]);
      cyc(4);
      chk("load", {amb[i] > 35, ld[5], amb[i] < 17, 1'b0, ld[2:0], 3'b000,
          ld[4:3]}, {rbl, fbl, fled, rled});
    end
    tset[31:24] <= 8'd20;
    cyc(440);
    rd(4'h4, st(7, 0));
    cyc(40);
    rd(4'h4, st(2, 0));
    chk("display", nd, {rbl, fbl, fled, rled});
    for (j = 0; j < 2; j++) begin
      tset[31:24] <= j ? 8'd60 : 8'd20;
      {bf, brb} <= 2'b11;
      cyc(9 * HC);
      rd(4'h4, st(3, 0));
      cyc(12);
      {bf, brb, bset} <= 3'b111;
      rd(4'h4, st(5, 0));
      chk("diag", 10'h3ff, {fled, rled});
      cyc(3);
      {bf, brb, bset} <= 3'b000;
      cyc(8 * HC);
      rd(4'h4, j ? st(6, 1) : st(2, 0));
      if (j) begin
        cyc(430);
        rd(4'h4, st(6, 1));
        cyc(50);
        rd(4'h4, st(2, 0));
      end
    end
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(24);
    rd(4'h4, st(1, 1));
    wr(4'h0, 32'h3);
    cyc(3);
    rd(4'h4, st(2, 0));
    chk("chimes", 5, n_chime);
    end_of_test();
  end
endmodule

// Checker attached to every controller instance
bind sdd_ctrl sdd_ctrl_monitor #(.HALF_CYC(HALF_CYC)) i_sdd_ctrl_monitor (
  .CLOCK_IN, .RESET_N_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
  .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
  .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT,
  .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .FRZ_LED_OUT,
  .REF_LED_OUT, .CONFIRM_CHIME_OUT);

//--- verification/sdd_ctrl_monitor.sv
// Checker on the controller ports: bus timing, lamps, chime pulse.
// Assumes binding to sdd_ctrl with the same HALF_CYC.
`timescale 1ns/1ps
module sdd_ctrl_monitor #(
  parameter HALF_CYC = 8
) (
  input wire        CLOCK_IN,
  input wire        RESET_N_IN,
  input wire        S_AXI_AWVALID_IN,
  input wire        S_AXI_AWREADY_OUT,
  input wire        S_AXI_WVALID_IN,
  input wire        S_AXI_WREADY_OUT,
  input wire        S_AXI_BVALID_OUT,
  input wire        S_AXI_BREADY_IN,
  input wire [3:0]  S_AXI_ARADDR_IN,
  input wire        S_AXI_ARVALID_IN,
  input wire        S_AXI_ARREADY_OUT,
  input wire [31:0] S_AXI_RDATA_OUT,
  input wire [1:0]  S_AXI_RRESP_OUT,
  input wire        S_AXI_RVALID_OUT,
  input wire        S_AXI_RREADY_IN,
  input wire [4:0]  FRZ_LED_OUT,
  input wire [4:0]  REF_LED_OUT,
  input wire        CONFIRM_CHIME_OUT
);
  reg [15:0] por_cnt_reg;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // Cycles since reset release, saturating so it never wraps
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN)
      por_cnt_reg <= 16'h0000;
    else if (por_cnt_reg != 16'hffff)
      por_cnt_reg <= por_cnt_reg + 16'h0001;
  end

  sequence s_wr_take;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
      S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  endsequence

  a_power_lamps: assert property (
    por_cnt_reg < 2 * HALF_CYC |-> FRZ_LED_OUT == 5'h1f && REF_LED_OUT == 5'h1f)
    else $error("Lamps off during power-on check");
  a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID_OUT)
    else $error("Write answer late");
  a_read_answer: assert property (
    s_rd_take |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
    else $error("Read answer late");
  a_unmapped_read: assert property (s_rd_take ##0 S_AXI_ARADDR_IN == 4'hc
    |=> S_AXI_RRESP_OUT == 2'b10 && S_AXI_RDATA_OUT == 32'h0)
    else $error("Unmapped read answer wrong");
  a_resp_holds: assert property (
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
    else $error("Write answer dropped");
  a_read_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("Read answer dropped");
  a_aw_refused: assert property (
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
    else $error("Second write address accepted");
  a_chime_pulse: assert property (
    CONFIRM_CHIME_OUT |=> !CONFIRM_CHIME_OUT)
    else $error("Chime longer than one cycle");
endmodule

//--- verification/sdd_panel_model.sv
// Far-side model: temperature sensors and ice-maker eject mechanism.
// Assumes bench targets change just after rising edges.
`timescale 1ns/1ps
module sdd_panel_model (
  input  wire        clk_in,
  input  wire [47:0] temp_set_in,
  input  wire [1:0]  eject_num_in,
  input  wire        eject_go_in,
  input  wire        normal_set_in,
  output reg  [47:0] temp_out,
  output reg         eject_out,
  output reg         normal_out
);
  reg [1:0] left_reg;

  // Known levels before the first edge
  initial begin
    temp_out = {6{8'd20}};
    eject_out = 1'b0;
    normal_out = 1'b0;
    left_reg = 2'b00;
  end

  // Sensors lag a cycle; ejects are one-cycle pulses with gaps
  always @(posedge clk_in) begin
    temp_out <= temp_set_in;
    normal_out <= normal_set_in;
    eject_out <= 1'b0;
    if (eject_go_in)
      left_reg <= eject_num_in;
    else if (left_reg != 2'b00 && !eject_out) begin
      eject_out <= 1'b1;
      left_reg <= left_reg - 2'b01;
    end
  end
endmodule
